// File: fifo_bus_cfg.svh
`ifndef FIFO_BUS_CFG_SVH
`define FIFO_BUS_CFG_SVH

// width of the parallel data bus and of one byte lane
`define DATA_WIDTH 32
`define LANE_BITS  8

// occupancy figures of the two-slot buffer
`define SLOT_COUNT 2'h2
`define SLOT_ONE   2'h1
`define SLOT_NONE  2'h0

// levels of the active-low strobes and flags
`define PIN_IDLE   1'h1
`define PIN_ACTIVE 1'h0

// off and on levels of enables and handshakes
`define OE_OFF     1'h0
`define OE_ON      1'h1
`define RDY_OFF    1'h0
`define RDY_ON     1'h1

`endif

// File: fifo_bus_pkg.sv
package fifo_bus_pkg;

	// signalling of the two status pins
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h1,
		MODE_MULTI  = 2'h2
	} bus_mode_type;

	// read sequence of the bus master
	typedef enum logic [2:0] {
		RD_IDLE   = 3'h1,
		RD_ENABLE = 3'h2,
		RD_STROBE = 3'h4
	} read_state_type;

endpackage

// File: fifo_bus_if.sv
`timescale 1ns/1ps
`include "fifo_bus_cfg.svh"

interface fifo_bus_if #(
	parameter int DATA_W = `DATA_WIDTH
) (
	input wire logic CLK
);
	localparam int BE_W = DATA_W / `LANE_BITS;

	// two-way data and byte lanes, one driver set per end
	logic [DATA_W-1:0] dev_data_out;
	logic [BE_W-1:0]   dev_be_out;
	logic              dev_bus_oe;
	logic [DATA_W-1:0] host_data_out;
	logic [BE_W-1:0]   host_be_out;
	logic              host_bus_oe;
	logic [DATA_W-1:0] data_bus;
	logic [BE_W-1:0]   byte_lane_enable;

	// status flags from the device, strobes from the master
	logic              tx_space_flag_low;
	logic              rx_data_flag_low;
	logic              wr_strobe_low;
	logic              rd_strobe_low;
	logic              out_enable_low;
	logic              chip_reset_low;
	logic              wakeup_low;

	// resolved wire level; undriven lanes read as pulled high
	assign data_bus = dev_bus_oe ? dev_data_out
		: (host_bus_oe ? host_data_out : '1);
	assign byte_lane_enable = dev_bus_oe ? dev_be_out
		: (host_bus_oe ? host_be_out : '1);

	modport dev_end (
		input  CLK,
		input  data_bus,
		input  byte_lane_enable,
		input  wr_strobe_low,
		input  rd_strobe_low,
		input  out_enable_low,
		input  chip_reset_low,
		input  wakeup_low,
		output dev_data_out,
		output dev_be_out,
		output dev_bus_oe,
		output tx_space_flag_low,
		output rx_data_flag_low
	);

	modport host_end (
		input  CLK,
		input  data_bus,
		input  byte_lane_enable,
		input  dev_bus_oe,
		input  tx_space_flag_low,
		input  rx_data_flag_low,
		output host_data_out,
		output host_be_out,
		output host_bus_oe,
		output wr_strobe_low,
		output rd_strobe_low,
		output out_enable_low,
		output chip_reset_low,
		output wakeup_low
	);
endinterface

// File: fifo_host_end.sv
`timescale 1ns/1ps
`include "fifo_bus_cfg.svh"

module two_slot_buffer #(
	parameter int W = `DATA_WIDTH
) (
	input  wire logic         CLK,
	input  wire logic         RST,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic              in_ready_next,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	output logic              out_valid_next,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [1:0]   count_q;
	logic [1:0]   count_d;
	logic         push;
	logic         pop;
	logic [W-1:0] slot1_q;

	// occupancy after this edge and the flags that follow from it
	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + `SLOT_ONE;
		else if (pop && !push)
			count_d = count_q - `SLOT_ONE;
		in_ready_next = (count_d != `SLOT_COUNT);
		out_valid_next = (count_d != `SLOT_NONE);
	end

	// registered occupancy and handshake flags
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			count_q <= `SLOT_NONE;
			in_ready <= `RDY_ON;
			out_valid <= `RDY_OFF;
		end
		else
		begin
			count_q <= count_d;
			in_ready <= in_ready_next;
			out_valid <= out_valid_next;
		end
	end

	// head slot is the output register, second slot queues behind it
	always_ff @(posedge CLK)
	begin
		if (pop)
		begin
			if (count_q == `SLOT_COUNT)
				out_data <= slot1_q;
			else if (push)
				out_data <= in_data;
		end
		else if (push && count_q == `SLOT_NONE)
			out_data <= in_data;
		if (push && count_d == `SLOT_COUNT)
			slot1_q <= in_data;
	end
endmodule

module fifo_host_end #(
	parameter int DATA_W = `DATA_WIDTH,
	parameter int BE_W   = DATA_W / `LANE_BITS
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	fifo_bus_if.host_end           BUS,
	input  wire logic              CHIP_RESET,
	input  wire logic              WAKE_REQ,
	input  wire logic              WR_VALID,
	output logic                   WR_READY,
	input  wire logic [DATA_W-1:0] WR_DATA,
	input  wire logic [BE_W-1:0]   WR_BE,
	output logic                   RD_VALID,
	input  wire logic              RD_READY,
	output logic [DATA_W-1:0]      RD_DATA,
	output logic [BE_W-1:0]        RD_BE
);
	import fifo_bus_pkg::*;

	localparam int WORD_W = DATA_W + BE_W;

	read_state_type    rd_state_q;
	logic [DATA_W-1:0] hold_data_q;
	logic [BE_W-1:0]   hold_be_q;
	logic              wr_low_q;
	logic              rd_low_q;
	logic              oe_low_q;
	logic              bus_oe_q;
	logic              reset_low_q;
	logic              wake_low_q;
	logic              wr_ready_q;
	logic              wr_load;
	logic              wr_start;
	logic              wr_done;
	logic              rd_start;
	logic              rd_take;
	logic              rx_room;
	logic [WORD_W-1:0] rx_word;

	// pins come straight from registers
	assign BUS.host_data_out = hold_data_q;
	assign BUS.host_be_out = hold_be_q;
	assign BUS.host_bus_oe = bus_oe_q;
	assign BUS.wr_strobe_low = wr_low_q;
	assign BUS.rd_strobe_low = rd_low_q;
	assign BUS.out_enable_low = oe_low_q;
	assign BUS.chip_reset_low = reset_low_q;
	assign BUS.wakeup_low = wake_low_q;
	assign WR_READY = wr_ready_q;

	// chip reset and wakeup requests, held low while requested
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			reset_low_q <= `PIN_ACTIVE;
			wake_low_q <= `PIN_IDLE;
		end
		else
		begin
			reset_low_q <= !CHIP_RESET;
			wake_low_q <= !WAKE_REQ;
		end
	end

	// write handshake decisions
	always_comb
	begin
		wr_load = WR_VALID && wr_ready_q;
		wr_start = !wr_ready_q && wr_low_q
			&& !BUS.tx_space_flag_low
			&& rd_state_q == RD_IDLE;
		wr_done = !wr_low_q && !BUS.tx_space_flag_low;
	end

	// word to write is held until the device has taken it
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			wr_ready_q <= `RDY_ON;
			hold_data_q <= '0;
			hold_be_q <= '0;
		end
		else if (wr_load)
		begin
			wr_ready_q <= `RDY_OFF;
			hold_data_q <= WR_DATA;
			hold_be_q <= WR_BE;
		end
		else if (wr_done)
			wr_ready_q <= `RDY_ON;
	end

	// write strobe and bus drive for one word
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			wr_low_q <= `PIN_IDLE;
			bus_oe_q <= `OE_OFF;
		end
		else if (wr_start)
		begin
			wr_low_q <= `PIN_ACTIVE;
			bus_oe_q <= `OE_ON;
		end
		else if (wr_done)
		begin
			wr_low_q <= `PIN_IDLE;
			bus_oe_q <= `OE_OFF;
		end
	end

	// read decisions: start only with data waiting and room to keep it
	always_comb
	begin
		rd_start = rd_state_q == RD_IDLE && wr_ready_q && rx_room
			&& !BUS.rx_data_flag_low;
		rd_take = rd_state_q == RD_STROBE && BUS.dev_bus_oe
			&& !BUS.rx_data_flag_low;
		rx_word = {BUS.byte_lane_enable, BUS.data_bus};
	end

	// read sequence: enable output, then strobe until a word is taken
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rd_state_q <= RD_IDLE;
			oe_low_q <= `PIN_IDLE;
			rd_low_q <= `PIN_IDLE;
		end
		else
		begin
			case (rd_state_q)
				RD_IDLE:
				begin
					if (rd_start)
					begin
						rd_state_q <= RD_ENABLE;
						oe_low_q <= `PIN_ACTIVE;
					end
				end
				RD_ENABLE:
				begin
					rd_state_q <= RD_STROBE;
					rd_low_q <= `PIN_ACTIVE;
				end
				RD_STROBE:
				begin
					if (rd_take)
					begin
						rd_state_q <= RD_IDLE;
						oe_low_q <= `PIN_IDLE;
						rd_low_q <= `PIN_IDLE;
					end
				end
				default:
				begin
					rd_state_q <= RD_IDLE;
					oe_low_q <= `PIN_IDLE;
					rd_low_q <= `PIN_IDLE;
				end
			endcase
		end
	end

	// received words queue here so a stalled user loses none
	two_slot_buffer #(
		.W (WORD_W)
	) rx_buf (
		.CLK            (CLK),
		.RST            (RST),
		.in_valid       (rd_take),
		.in_ready       (rx_room),
		.in_ready_next  (),
		.in_data        (rx_word),
		.out_valid      (RD_VALID),
		.out_valid_next (),
		.out_ready      (RD_READY),
		.out_data       ({RD_BE, RD_DATA})
	);
endmodule

// File: fifo_dev_end.sv
`timescale 1ns/1ps
`include "fifo_bus_cfg.svh"

module fifo_dev_end #(
	parameter int DATA_W = `DATA_WIDTH,
	parameter int BE_W   = DATA_W / `LANE_BITS
) (
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire fifo_bus_pkg::bus_mode_type MODE,
	fifo_bus_if.dev_end                 BUS,
	output logic                        TX_VALID,
	input  wire logic                   TX_READY,
	output logic [DATA_W-1:0]           TX_DATA,
	output logic [BE_W-1:0]             TX_BE,
	input  wire logic                   RX_VALID,
	output logic                        RX_READY,
	input  wire logic [DATA_W-1:0]      RX_DATA,
	input  wire logic [BE_W-1:0]        RX_BE,
	output logic                        WAKE_SEEN
);
	import fifo_bus_pkg::*;

	localparam int WORD_W = DATA_W + BE_W;

	logic              chip_rst;
	logic              wr_take;
	logic              rd_take;
	logic              tx_room;
	logic              tx_room_next;
	logic              rx_have;
	logic              rx_have_next;
	logic              rd_req;
	logic              drive_q;
	logic              tx_flag_q;
	logic              rx_flag_q;
	logic              wake_q;
	logic [WORD_W-1:0] rx_head;

	// pins come straight from registers
	assign BUS.dev_data_out = rx_head[DATA_W-1:0];
	assign BUS.dev_be_out = rx_head[WORD_W-1:DATA_W];
	assign BUS.dev_bus_oe = drive_q;
	assign BUS.tx_space_flag_low = tx_flag_q;
	assign BUS.rx_data_flag_low = rx_flag_q;
	assign WAKE_SEEN = wake_q;

	// reset from either the local reset or the chip-reset pin
	always_comb
	begin
		chip_rst = RST || !BUS.chip_reset_low;
		wr_take = !BUS.wr_strobe_low && tx_room;
		rd_req = !BUS.rd_strobe_low && drive_q;
		rd_take = rd_req && rx_have;
	end

	// master-written words with their lane enables
	two_slot_buffer #(
		.W (WORD_W)
	) tx_buf (
		.CLK            (CLK),
		.RST            (chip_rst),
		.in_valid       (wr_take),
		.in_ready       (tx_room),
		.in_ready_next  (tx_room_next),
		.in_data        ({BUS.byte_lane_enable, BUS.data_bus}),
		.out_valid      (TX_VALID),
		.out_valid_next (),
		.out_ready      (TX_READY),
		.out_data       ({TX_BE, TX_DATA})
	);

	// words waiting for the master; head slot drives the bus
	two_slot_buffer #(
		.W (WORD_W)
	) rx_buf (
		.CLK            (CLK),
		.RST            (chip_rst),
		.in_valid       (RX_VALID),
		.in_ready       (RX_READY),
		.in_ready_next  (),
		.in_data        ({RX_BE, RX_DATA}),
		.out_valid      (rx_have),
		.out_valid_next (rx_have_next),
		.out_ready      (rd_req),
		.out_data       (rx_head)
	);

	// bus drive follows output enable one edge later
	always_ff @(posedge CLK)
	begin
		if (chip_rst)
			drive_q <= `OE_OFF;
		else
			drive_q <= !BUS.out_enable_low;
	end

	// status pins: fill flags or, in multi mode, one-cycle pulses
	always_ff @(posedge CLK)
	begin
		if (chip_rst)
		begin
			tx_flag_q <= `PIN_IDLE;
			rx_flag_q <= `PIN_IDLE;
		end
		else if (MODE == MODE_MULTI)
		begin
			tx_flag_q <= !wr_take;
			rx_flag_q <= !rd_take;
		end
		else
		begin
			tx_flag_q <= !tx_room_next;
			rx_flag_q <= !rx_have_next;
		end
	end

	// wakeup request level seen on the pin
	always_ff @(posedge CLK)
	begin
		if (chip_rst)
			wake_q <= `RDY_OFF;
		else
			wake_q <= !BUS.wakeup_low;
	end
endmodule

// File: fifo_bus_props.sv
`timescale 1ns/1ps
module fifo_bus_props
	import fifo_bus_pkg::*;
(
	input wire logic                       CLK,
	input wire logic                       RST,
	input wire fifo_bus_pkg::bus_mode_type MODE,
	input wire logic                       wr_strobe_low,
	input wire logic                       rd_strobe_low,
	input wire logic                       out_enable_low,
	input wire logic                       chip_reset_low,
	input wire logic                       tx_space_flag_low,
	input wire logic                       rx_data_flag_low,
	input wire logic                       dev_bus_oe,
	input wire logic                       host_bus_oe
);
	// every check on the rising bus clock, quiet while in reset
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);

	// master strobes only behind the matching ready flag
	write_gate_a: assert property (
		!wr_strobe_low && MODE == MODE_SINGLE |-> !$past(tx_space_flag_low))
		else $error("write without space flag");
	read_gate_a: assert property (
		$fell(out_enable_low) && MODE == MODE_SINGLE
		|-> !$past(rx_data_flag_low)) else $error("read without data flag");

	// device drives the bus only after output enable, one edge late
	oe_first_a: assert property (
		dev_bus_oe |-> !$past(out_enable_low)) else $error("early drive");
	oe_lag_a: assert property (
		$fell(out_enable_low) |=> dev_bus_oe) else $error("drive missing");

	// never two drivers, host drives exactly with its write strobe
	one_driver_a: assert property (
		!(dev_bus_oe && host_bus_oe)) else $error("bus contention");
	host_drive_a: assert property (
		host_bus_oe == !wr_strobe_low) else $error("host drive mismatch");
	read_drive_a: assert property (
		!rd_strobe_low |-> dev_bus_oe && !out_enable_low)
		else $error("read strobe while undriven");

	// chip reset parks the device outputs
	chip_reset_a: assert property (
		!chip_reset_low |=> tx_space_flag_low && rx_data_flag_low
		&& !dev_bus_oe) else $error("chip reset ignored");

	// multi mode pins pulse only after a taken transfer
	status_pulse_a: assert property (
		MODE == MODE_MULTI && $past(MODE) == MODE_MULTI
		&& !tx_space_flag_low |-> !$past(wr_strobe_low))
		else $error("stray status pulse");
	ack_pulse_a: assert property (
		MODE == MODE_MULTI && $past(MODE) == MODE_MULTI
		&& !rx_data_flag_low |-> !$past(rd_strobe_low))
		else $error("stray receive ack");
endmodule

// File: sync_fifo_bus_pin_handshake_test.sv
`timescale 1ns/1ps
module sync_fifo_bus_pin_handshake_test;
	import fifo_bus_pkg::*;

	// user-side stimulus and results of both ends
	logic         clk = 1'h0, rst = 1'h1, hold = 1'h0;
	logic         chip_reset = 1'h0, wake_req = 1'h0, wake_seen;
	logic         wr_valid = 1'h0, wr_ready, rd_valid, rd_ready = 1'h0;
	logic         tx_valid, tx_ready = 1'h0, rx_valid = 1'h0, rx_ready;
	logic [31:0]  wr_data = '0, rd_data, tx_data, rx_data = '0;
	logic [3:0]   wr_be = '0, rd_be, tx_be, rx_be = '0;
	logic [35:0]  wq[$], rq[$];
	bus_mode_type mode = MODE_SINGLE;
	int           num_errors = 0, n_tests = 0, cyc = 0;

	// 125 MHz bus clock
	initial
		forever #4 clk = ~clk;

	fifo_bus_if bus (.CLK(clk));
	fifo_host_end fifo_host_end_inst (
		.CLK(clk), .RST(rst), .BUS(bus), .CHIP_RESET(chip_reset),
		.WAKE_REQ(wake_req), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.WR_DATA(wr_data), .WR_BE(wr_be), .RD_VALID(rd_valid),
		.RD_READY(rd_ready), .RD_DATA(rd_data), .RD_BE(rd_be)
	);
	fifo_dev_end fifo_dev_end_inst (
		.CLK(clk), .RST(rst), .MODE(mode), .BUS(bus),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
		.TX_BE(tx_be), .RX_VALID(rx_valid), .RX_READY(rx_ready),
		.RX_DATA(rx_data), .RX_BE(rx_be), .WAKE_SEEN(wake_seen)
	);
	fifo_bus_props props_inst (
		.CLK(clk), .RST(rst), .MODE(mode),
		.wr_strobe_low(bus.wr_strobe_low),
		.rd_strobe_low(bus.rd_strobe_low),
		.out_enable_low(bus.out_enable_low),
		.chip_reset_low(bus.chip_reset_low),
		.tx_space_flag_low(bus.tx_space_flag_low),
		.rx_data_flag_low(bus.rx_data_flag_low),
		.dev_bus_oe(bus.dev_bus_oe),
		.host_bus_oe(bus.host_bus_oe)
	);

	task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		n_tests++;
		if (s !== e)
		begin
			$display("mismatch %s exp %h got %h", nm, e, s);
			num_errors++;
		end
	endtask

	// expected word: oldest one sent in that direction
	function logic [35:0] pop(input bit d);
		if (d)
			return rq.size() ? rq.pop_front() : 'x;
		return wq.size() ? wq.pop_front() : 'x;
	endfunction

	function logic [35:0] rnd();
		return {4'($urandom), $urandom};
	endfunction

	// offer one word, return at the edge that takes it
	task send(input bit d, input logic [35:0] w);
		wr_valid <= !d;
		rx_valid <= d;
		{wr_be, wr_data} <= w;
		{rx_be, rx_data} <= w;
		if (d)
			rq.push_back(w);
		else
			wq.push_back(w);
		@(negedge clk);
		while ((d ? rx_ready : wr_ready) !== 1'h1)
			@(negedge clk);
		@(posedge clk);
	endtask

	task drain;
		while (wq.size() || rq.size())
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask

	task done(input string nm);
		$display("test %s done", nm);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// random receiver stalls, forced off while hold is set
	always @(posedge clk)
	begin
		tx_ready <= !hold && ($urandom_range(3) != 0);
		rd_ready <= !hold && ($urandom_range(3) != 0);
	end

	// delivered words come out in order, lanes paired with bytes
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			chk("tx word", pop(0), {tx_be, tx_data});
		if (rd_valid && rd_ready)
			chk("rd word", pop(1), {rd_be, rd_data});
	end

	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			final_report;
		end
	end

	initial
	begin
		void'($urandom(86));
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		repeat (8) @(posedge clk);
		send(0, 36'hF_FFFF_FFFF);
		send(1, 36'h0_0000_0000);
		send(0, 36'h5_A5A5_0F0F);
		for (int i = 0; i < 24; i++)
			send(1'($urandom), rnd());
		wr_valid <= 1'h0;
		rx_valid <= 1'h0;
		drain;
		done("stream");
		hold <= 1'h1;
		// two writes fill the device, four reads fill both receive sides
		for (int i = 0; i < 6; i++)
			send(i > 1, rnd());
		rx_valid <= 1'h0;
		repeat (10) @(posedge clk);
		chk("space flag", 1, bus.tx_space_flag_low);
		chk("data flag", 0, bus.rx_data_flag_low);
		chk("host word", 1, rd_valid);
		chk("rx full", 0, rx_ready);
		hold <= 1'h0;
		drain;
		done("fill");
		chip_reset <= 1'h1;
		repeat (3) @(posedge clk);
		chk("reset space", 1, bus.tx_space_flag_low);
		chk("reset drive", 0, bus.dev_bus_oe);
		chip_reset <= 1'h0;
		repeat (6) @(posedge clk);
		chk("room", 0, bus.tx_space_flag_low);
		done("chip reset");
		wake_req <= 1'h1;
		repeat (4) @(posedge clk);
		chk("wake", 1, wake_seen);
		wake_req <= 1'h0;
		repeat (4) @(posedge clk);
		chk("wake", 0, wake_seen);
		done("wakeup");
		// switch to multi mode just before the device takes a bus write
		send(0, rnd());
		wr_valid <= 1'h0;
		@(posedge clk);
		mode <= MODE_MULTI;
		@(posedge clk);
		@(negedge clk);
		chk("status pulse", 0, bus.tx_space_flag_low);
		@(posedge clk);
		mode <= MODE_SINGLE;
		// switch to multi mode once output enable has fallen for a read
		send(1, rnd());
		rx_valid <= 1'h0;
		@(posedge clk);
		while (bus.out_enable_low !== 1'h0)
			@(posedge clk);
		mode <= MODE_MULTI;
		@(posedge clk);
		@(negedge clk);
		chk("ack pulse", 0, bus.rx_data_flag_low);
		@(posedge clk);
		drain;
		// in multi mode the data flag stays high with no read, so the host never starts a read and the word waits in the device
		send(1, rnd());
		rx_valid <= 1'h0;
		repeat (10) @(posedge clk);
		chk("ack", 1, bus.rx_data_flag_low);
		chk("status", 1, bus.tx_space_flag_low);
		chk("no read", 0, rd_valid);
		mode <= MODE_SINGLE;
		drain;
		done("multi");
		final_report;
	end
endmodule
